// file: hw/exc_top.sv
// mode selection, setpoint handling and protection supervision with an apb register file
`timescale 1ns/1ps
`include "exc_regs.svh"

// Functional notes
// - voltage and field-current modes standard; reactive and pf modes need the option
// - voltage mode target follows setpoint moved by contacts or software
// - field-current setpoint clamped to 0..3 A
// - reactive setpoint clamped to 100 percent absorb..100 percent generate
// - reactive or pf control runs only while software on and contact open
// - power factor setpoint clamped between 0.6 lag and 0.6 lead
// - droop lowers target for lagging load, raises for leading
// - droop setting at most 10 percent at rated reactive current
// - droop on while parallel contact open; with option both contacts closed disable
// - below knee target follows per-unit volts per hertz curve; indicator flashes
// - knee 40..65 Hz, slope 1..3 in 0.01 steps, defaults 59 Hz, 2
// - unloading starts when drop below knee reaches the offset setting and falling rate exceeds the rate setting
// - unloading offset 0.9..9.0 Hz in 0.1 Hz steps, default 0.9
// - rate setting 0..25.5 Hz per 25 ms; change measured every 25 ms
// - unloading drops voltage percentage per 1.5 percent frequency fall, 1..20
// - unloading ends after 1..5 s, then normal underfrequency curve
// - each protective function drives its indicator and reports in status
// - enabled field overvoltage flashes at once, alarms and shuts down after 15 s
// - first power-up after an overvoltage shutdown flashes that indicator 5 s
// - generator overvoltage held 0.75 s flashes, alarms and shuts down
// - temperature above 70 C flashes, alarms and shuts down
// - closed raise or lower contact keeps moving the active setpoint
// - reactive or pf control wins over droop when both contacts open
// - alarm relay closed only while a trip condition is present
module exc_top #(
   parameter int TICK_CYCLES = `EXC_TICK_NS / `EXC_CLK_NS
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // measurements from the front end, same clock
   input wire exc_pkg::exc_meas_t meas,
   // contact and strap pins
   input wire exc_pkg::exc_contact_t contacts,
   input wire logic option_fitted,
   input wire logic [1:0] boot_trip,
   // results
   output exc_pkg::exc_mode_t active_mode,
   output logic [15:0] active_setpoint,
   output exc_pkg::exc_ind_t indicators,
   output logic alarm_relay,
   output logic shutdown,
   output exc_pkg::exc_trip_t last_trip
);
   import exc_pkg::*;

   function automatic logic [15:0] clampu(input logic [15:0] v, input logic [15:0] lo,
                                          input logic [15:0] hi);
      clampu = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction

   function automatic logic [15:0] clamps(input logic [15:0] v, input logic [15:0] lim);
      logic signed [15:0] s;
      s = $signed(v);
      clamps = (s > $signed(lim)) ? lim : ((s < -$signed(lim)) ? 16'(-$signed(lim)) : v);
   endfunction

   // pin synchronisers: first stage read only by the second
   logic [6:0] sync1_q, sync2_q;
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         sync1_q <= 7'h00;
         sync2_q <= 7'h00;
      end else begin
         sync1_q <= {option_fitted, boot_trip, contacts};
         sync2_q <= sync1_q;
      end
   end
   exc_contact_t cin;
   logic opt;
   assign cin = sync2_q[3:0];
   assign opt = sync2_q[6];

   // millisecond tick
   logic [15:0] tick_cnt_q;
   logic tick;
   assign tick = (tick_cnt_q == 16'(TICK_CYCLES - 1));
   always_ff @(posedge clock) begin
      if (!rst_n || tick) tick_cnt_q <= 16'h0000;
      else tick_cnt_q <= tick_cnt_q + 16'h0001;
   end

   // registers
   exc_mode_t mode_q;
   logic rsw_q, fov_en_q;
   logic [15:0] vset_q, fset_q, qset_q, pfset_q, droop_q, knee_q, slope_q, fovset_q, govset_q;
   logic [7:0] ofs_q, rate_q, pct_q, time_q;
   logic [31:0] status;
   logic [31:0] rdata;
   logic rd_ok;
   logic wr;
   logic [15:0] wd;
   logic [7:0] rl_cnt_q;
   logic rl_step;
   assign wr = psel && penable && pready && pwrite;
   assign wd = pwdata[15:0];
   assign rl_step = tick && (rl_cnt_q == 8'(`EXC_RL_MS - 1));

   always_ff @(posedge clock) begin
      if (!rst_n || rl_step) rl_cnt_q <= 8'h00;
      else if (tick) rl_cnt_q <= rl_cnt_q + 8'h01;
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         mode_q <= EXC_MODE_VOLT;
         rsw_q <= 1'b0;
         fov_en_q <= 1'b0;
         droop_q <= `EXC_RST_DROOP;
         knee_q <= `EXC_RST_KNEE;
         slope_q <= `EXC_RST_SLOPE;
         ofs_q <= `EXC_RST_OFS;
         rate_q <= `EXC_RST_RATE;
         pct_q <= `EXC_RST_PCT;
         time_q <= `EXC_RST_TIME;
         fovset_q <= `EXC_RST_FOVSET;
         govset_q <= `EXC_RST_GOVSET;
      end else if (wr) begin
         case (paddr)
            `EXC_OFF_CTRL: begin
               mode_q <= exc_mode_t'(pwdata[`EXC_CTRL_MODE_LSB +: 2]);
               rsw_q <= pwdata[`EXC_CTRL_RSW_BIT];
               fov_en_q <= pwdata[`EXC_CTRL_FOVEN_BIT];
            end
            `EXC_OFF_DROOP: droop_q <= clampu(wd, 16'h0000, `EXC_DROOP_MAX);
            `EXC_OFF_KNEE: knee_q <= clampu(wd, `EXC_KNEE_MIN, `EXC_KNEE_MAX);
            `EXC_OFF_SLOPE: slope_q <= clampu(wd, `EXC_SLOPE_MIN, `EXC_SLOPE_MAX);
            `EXC_OFF_UNLD: begin
               ofs_q <= 8'(clampu({8'h00, pwdata[`EXC_UNLD_OFS_LSB +: 8]},
                                  {8'h00, `EXC_OFS_MIN}, {8'h00, `EXC_OFS_MAX}));
               rate_q <= pwdata[`EXC_UNLD_RATE_LSB +: 8];
               pct_q <= 8'(clampu({8'h00, pwdata[`EXC_UNLD_PCT_LSB +: 8]},
                                  {8'h00, `EXC_PCT_MIN}, {8'h00, `EXC_PCT_MAX}));
               time_q <= 8'(clampu({8'h00, pwdata[`EXC_UNLD_TIME_LSB +: 8]},
                                   {8'h00, `EXC_TIME_MIN}, {8'h00, `EXC_TIME_MAX}));
            end
            `EXC_OFF_FOVSET: fovset_q <= wd;
            `EXC_OFF_GOVSET: govset_q <= wd;
            default: ;
         endcase
      end
   end

   // setpoints: software write wins over a contact step in the same cycle
   logic up, dn;
   assign up = cin.raise && !cin.lower && rl_step;
   assign dn = cin.lower && !cin.raise && rl_step;
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         vset_q <= `EXC_RST_VSET;
         fset_q <= `EXC_RST_FSET;
         qset_q <= 16'h0000;
         pfset_q <= 16'h0000;
      end else if (wr && paddr == `EXC_OFF_VSET) begin
         vset_q <= clampu(wd, 16'h0000, `EXC_VSET_MAX);
      end else if (wr && paddr == `EXC_OFF_FSET) begin
         fset_q <= clampu(wd, 16'h0000, `EXC_FSET_MAX);
      end else if (wr && paddr == `EXC_OFF_QSET) begin
         qset_q <= clamps(wd, `EXC_QSET_LIM);
      end else if (wr && paddr == `EXC_OFF_PFSET) begin
         pfset_q <= clamps(wd, `EXC_PFSET_LIM);
      end else if (up || dn) begin
         case (active_mode)
            EXC_MODE_VOLT: vset_q <= clampu(up ? vset_q + 16'h0001 : vset_q - 16'h0001 +
                                            ((vset_q == 16'h0000) ? 16'h0001 : 16'h0000),
                                            16'h0000, `EXC_VSET_MAX);
            EXC_MODE_FIELD: fset_q <= clampu(up ? fset_q + 16'h0001 : fset_q - 16'h0001 +
                                             ((fset_q == 16'h0000) ? 16'h0001 : 16'h0000),
                                             16'h0000, `EXC_FSET_MAX);
            EXC_MODE_VAR: qset_q <= clamps(up ? qset_q + 16'h0001 : qset_q - 16'h0001,
                                           `EXC_QSET_LIM);
            EXC_MODE_PF: pfset_q <= clamps(up ? pfset_q + 16'h0001 : pfset_q - 16'h0001,
                                           `EXC_PFSET_LIM);
            default: ;
         endcase
      end
   end

   // mode resolution
   logic reactive_run, droop_run;
   exc_mode_t mode_d;
   assign reactive_run = opt && rsw_q && !cin.reactive_control_contact;
   assign droop_run = opt ? !(cin.parallel_comp_contact && cin.reactive_control_contact)
                          : !cin.parallel_comp_contact;
   always_comb begin
      mode_d = mode_q;
      if ((mode_q == EXC_MODE_VAR || mode_q == EXC_MODE_PF) && !reactive_run) begin
         mode_d = EXC_MODE_VOLT;
      end
   end

   // frequency change over each 25 ms window
   logic [7:0] win_cnt_q;
   logic [15:0] fprev_q, fdrop_q;
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         win_cnt_q <= 8'h00;
         fprev_q <= 16'h0000;
         fdrop_q <= 16'h0000;
      end else if (tick) begin
         if (win_cnt_q == 8'(`EXC_RATE_MS - 1)) begin
            win_cnt_q <= 8'h00;
            fprev_q <= meas.freq;
            fdrop_q <= (fprev_q > meas.freq) ? fprev_q - meas.freq : 16'h0000;
         end else begin
            win_cnt_q <= win_cnt_q + 8'h01;
         end
      end
   end

   // underfrequency and unloading arithmetic, all in 0.1 percent of nominal
   logic below_knee;
   logic [15:0] fgap;
   logic [31:0] rel, uf_red, ul_red;
   assign below_knee = meas.freq < knee_q;
   assign fgap = below_knee ? knee_q - meas.freq : 16'h0000;
   assign rel = ({16'h0000, fgap} * 32'd1000) / {16'h0000, knee_q};
   // full precision here: truncating rel first would cost a unit on the curve
   assign uf_red = ({16'h0000, slope_q} * {16'h0000, fgap} * 32'd10) / {16'h0000, knee_q};
   assign ul_red = ({24'h000000, pct_q} * 32'd10 * rel) / 32'd15;

   // unloading state machine
   exc_ul_t ul_q;
   logic [15:0] ul_ms_q;
   logic ul_start;
   assign ul_start = below_knee && (fgap >= 16'({8'h00, ofs_q} * 16'd10)) &&
                     (fdrop_q > 16'({8'h00, rate_q} * 16'd10));
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ul_q <= EXC_UL_IDLE;
         ul_ms_q <= 16'h0000;
      end else begin
         case (ul_q)
            EXC_UL_IDLE: begin
               ul_ms_q <= 16'h0000;
               if (ul_start) ul_q <= EXC_UL_ACTIVE;
            end
            EXC_UL_ACTIVE: begin
               if (tick) ul_ms_q <= ul_ms_q + 16'h0001;
               if (ul_ms_q >= 16'({8'h00, time_q} * 16'(`EXC_SEC_MS))) begin
                  ul_q <= EXC_UL_DONE;
               end
            end
            EXC_UL_DONE: if (!below_knee) ul_q <= EXC_UL_IDLE;
            default: ul_q <= EXC_UL_IDLE;
         endcase
      end
   end

   // voltage target
   logic [31:0] dr_off, base, red, vtgt;
   always_comb begin
      dr_off = 32'($signed({16'h0000, droop_q}) * $signed({{16{meas.iq[15]}}, meas.iq})
                   / 32'sd1000);
      base = {16'h0000, vset_q};
      if (droop_run && !reactive_run) begin
         base = 32'($signed(base) - $signed(dr_off));
         if ($signed(base) < 0) base = 32'h00000000;
      end
      red = uf_red + ((ul_q == EXC_UL_ACTIVE) ? ul_red : 32'h00000000);
      if (red > 32'd1000) red = 32'd1000;
      vtgt = base - (base * red) / 32'd1000;
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         active_mode <= EXC_MODE_VOLT;
         active_setpoint <= `EXC_RST_VSET;
      end else begin
         active_mode <= mode_d;
         case (mode_d)
            EXC_MODE_VOLT: active_setpoint <= vtgt[15:0];
            EXC_MODE_FIELD: active_setpoint <= fset_q;
            EXC_MODE_VAR: active_setpoint <= qset_q;
            EXC_MODE_PF: active_setpoint <= pfset_q;
            default: active_setpoint <= vtgt[15:0];
         endcase
      end
   end

   // protection
   logic fov_cond, gov_cond, ot_cond;
   logic [15:0] fov_ms_q, gov_ms_q, boot_ms_q, blink_ms_q;
   logic fov_hit, gov_hit, blink_q, boot_done_q;
   logic [1:0] settle_q;
   exc_trip_t boot_trip_q;
   assign fov_cond = fov_en_q && (meas.vfield > fovset_q);
   assign gov_cond = meas.vrms > govset_q;
   assign ot_cond = meas.temp > `EXC_OT_LIMIT;
   assign fov_hit = fov_cond && (fov_ms_q >= 16'(`EXC_FOV_MS));
   assign gov_hit = gov_cond && (gov_ms_q >= 16'(`EXC_GOV_MS));

   always_ff @(posedge clock) begin
      if (!rst_n || !fov_cond) fov_ms_q <= 16'h0000;
      else if (tick && !fov_hit) fov_ms_q <= fov_ms_q + 16'h0001;
   end
   always_ff @(posedge clock) begin
      if (!rst_n || !gov_cond) gov_ms_q <= 16'h0000;
      else if (tick && !gov_hit) gov_ms_q <= gov_ms_q + 16'h0001;
   end
   // slow blink shared by all flashing indicators
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         blink_ms_q <= 16'h0000;
         blink_q <= 1'b0;
      end else if (tick) begin
         if (blink_ms_q == 16'(`EXC_BLINK_MS - 1)) begin
            blink_ms_q <= 16'h0000;
            blink_q <= !blink_q;
         end else begin
            blink_ms_q <= blink_ms_q + 16'h0001;
         end
      end
   end
   // stored trip is sampled once the synchronisers have settled after reset
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         boot_ms_q <= 16'h0000;
         boot_done_q <= 1'b0;
         boot_trip_q <= EXC_TRIP_NONE;
         settle_q <= 2'h0;
      end else begin
         if (settle_q != 2'h3) settle_q <= settle_q + 2'h1;
         if (!boot_done_q && settle_q == 2'h2) begin
            boot_trip_q <= exc_trip_t'(sync2_q[5:4]);
            boot_done_q <= 1'b1;
         end
         if (boot_done_q && tick && boot_ms_q < 16'(`EXC_BOOT_MS)) begin
            boot_ms_q <= boot_ms_q + 16'h0001;
         end
      end
   end

   logic boot_flash;
   assign boot_flash = boot_done_q && (boot_ms_q < 16'(`EXC_BOOT_MS)) && blink_q;
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         indicators <= '0;
         alarm_relay <= 1'b0;
         shutdown <= 1'b0;
         last_trip <= EXC_TRIP_NONE;
      end else begin
         indicators.uf <= below_knee && blink_q;
         indicators.fov <= (fov_cond && blink_q) ||
                           (boot_flash && boot_trip_q == EXC_TRIP_FOV);
         indicators.gov <= (gov_hit && blink_q) ||
                           (boot_flash && boot_trip_q == EXC_TRIP_GOV);
         indicators.ot <= ot_cond && blink_q;
         alarm_relay <= fov_hit || gov_hit || ot_cond;
         // excitation stays off until the next reset, even if the cause clears
         if (fov_hit || gov_hit || ot_cond) shutdown <= 1'b1;
         if (!shutdown) begin
            if (fov_hit) last_trip <= EXC_TRIP_FOV;
            else if (gov_hit) last_trip <= EXC_TRIP_GOV;
            else if (ot_cond) last_trip <= EXC_TRIP_OT;
         end
      end
   end

   // status and apb read path; answer registered in the setup cycle, zero wait
   assign status = {16'h0000, opt, boot_trip_q, last_trip, shutdown, alarm_relay, ot_cond,
                    gov_hit, fov_cond, ul_q == EXC_UL_ACTIVE, below_knee,
                    droop_run && !reactive_run, reactive_run, active_mode};
   always_comb begin
      rd_ok = 1'b1;
      case (paddr)
         `EXC_OFF_CTRL: rdata = {28'h0000000, fov_en_q, rsw_q, mode_q};
         `EXC_OFF_VSET: rdata = {16'h0000, vset_q};
         `EXC_OFF_FSET: rdata = {16'h0000, fset_q};
         `EXC_OFF_QSET: rdata = {16'h0000, qset_q};
         `EXC_OFF_PFSET: rdata = {16'h0000, pfset_q};
         `EXC_OFF_DROOP: rdata = {16'h0000, droop_q};
         `EXC_OFF_KNEE: rdata = {16'h0000, knee_q};
         `EXC_OFF_SLOPE: rdata = {16'h0000, slope_q};
         `EXC_OFF_UNLD: rdata = {time_q, pct_q, rate_q, ofs_q};
         `EXC_OFF_FOVSET: rdata = {16'h0000, fovset_q};
         `EXC_OFF_GOVSET: rdata = {16'h0000, govset_q};
         `EXC_OFF_STATUS: rdata = status;
         default: begin
            rdata = 32'h00000000;
            rd_ok = 1'b0;
         end
      endcase
   end
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !rd_ok;
         prdata <= (psel && !penable && !pwrite) ? rdata : 32'h00000000;
      end
   end
endmodule

// file: pkg/exc_regs.svh
// register offsets, reset values, limits and timing counts of the excitation supervisor
`ifndef EXC_REGS_SVH
`define EXC_REGS_SVH
`define EXC_CLK_NS 50
`define EXC_TICK_NS 1000000
`define EXC_RATE_MS 25
`define EXC_GOV_MS 750
`define EXC_FOV_MS 15000
`define EXC_BOOT_MS 5000
`define EXC_BLINK_MS 250
`define EXC_RL_MS 10
`define EXC_SEC_MS 1000
`define EXC_OT_LIMIT 8'd70
`define EXC_OFF_CTRL 8'h00
`define EXC_OFF_VSET 8'h04
`define EXC_OFF_FSET 8'h08
`define EXC_OFF_QSET 8'h0C
`define EXC_OFF_PFSET 8'h10
`define EXC_OFF_DROOP 8'h14
`define EXC_OFF_KNEE 8'h18
`define EXC_OFF_SLOPE 8'h1C
`define EXC_OFF_UNLD 8'h20
`define EXC_OFF_FOVSET 8'h24
`define EXC_OFF_GOVSET 8'h28
`define EXC_OFF_STATUS 8'h2C
`define EXC_CTRL_MODE_LSB 0
`define EXC_CTRL_RSW_BIT 2
`define EXC_CTRL_FOVEN_BIT 3
`define EXC_UNLD_OFS_LSB 0
`define EXC_UNLD_RATE_LSB 8
`define EXC_UNLD_PCT_LSB 16
`define EXC_UNLD_TIME_LSB 24
`define EXC_RST_VSET 16'h03E8
`define EXC_RST_FSET 16'h0000
`define EXC_RST_DROOP 16'h0000
`define EXC_RST_KNEE 16'h170C
`define EXC_RST_SLOPE 16'h00C8
`define EXC_RST_OFS 8'h09
`define EXC_RST_RATE 8'h01
`define EXC_RST_PCT 8'h02
`define EXC_RST_TIME 8'h01
`define EXC_RST_FOVSET 16'h0320
`define EXC_RST_GOVSET 16'h04B0
`define EXC_FSET_MAX 16'h0BB8
`define EXC_QSET_LIM 16'h03E8
`define EXC_PFSET_LIM 16'h0190
`define EXC_DROOP_MAX 16'h0064
`define EXC_KNEE_MIN 16'h0FA0
`define EXC_KNEE_MAX 16'h1964
`define EXC_SLOPE_MIN 16'h0064
`define EXC_SLOPE_MAX 16'h012C
`define EXC_OFS_MIN 8'h09
`define EXC_OFS_MAX 8'h5A
`define EXC_PCT_MIN 8'h01
`define EXC_PCT_MAX 8'h14
`define EXC_TIME_MIN 8'h01
`define EXC_TIME_MAX 8'h05
`define EXC_VSET_MAX 16'h07D0
`endif

// file: pkg/exc_pkg.sv
// types of the excitation supervisor
package exc_pkg;
   typedef enum logic [1:0] {
      EXC_MODE_VOLT = 2'h0,
      EXC_MODE_FIELD = 2'h1,
      EXC_MODE_VAR = 2'h2,
      EXC_MODE_PF = 2'h3
   } exc_mode_t;
   typedef enum logic [1:0] {
      EXC_TRIP_NONE = 2'h0,
      EXC_TRIP_FOV = 2'h1,
      EXC_TRIP_GOV = 2'h2,
      EXC_TRIP_OT = 2'h3
   } exc_trip_t;
   typedef enum logic [1:0] {
      EXC_UL_IDLE = 2'b00,
      EXC_UL_ACTIVE = 2'b01,
      EXC_UL_DONE = 2'b11
   } exc_ul_t;
   typedef struct packed {
      logic [15:0] vrms;
      logic [15:0] vfield;
      logic [15:0] freq;
      logic [7:0] temp;
      logic signed [15:0] iq;
   } exc_meas_t;
   typedef struct packed {
      logic raise;
      logic lower;
      logic reactive_control_contact;
      logic parallel_comp_contact;
   } exc_contact_t;
   typedef struct packed {
      logic uf;
      logic fov;
      logic gov;
      logic ot;
   } exc_ind_t;
endpackage

// file: verification/exc_checker.sv
// port assertions of the excitation supervisor
`timescale 1ns/1ps
module exc_checker import exc_pkg::*; #(
   parameter int TICK_CYCLES = 20
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   // pins
   input wire exc_pkg::exc_meas_t meas,
   input wire exc_pkg::exc_contact_t contacts,
   input wire logic option_fitted,
   // results
   input wire exc_pkg::exc_mode_t active_mode,
   input wire logic [15:0] active_setpoint,
   input wire logic alarm_relay,
   input wire logic shutdown,
   input wire exc_pkg::exc_trip_t last_trip
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   chk_ready_next: assert property (psel && !penable |=> pready) else $error("no pready");
   chk_err_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
   chk_alarm_shut: assert property (alarm_relay |-> shutdown) else $error("alarm");
   chk_shut_stays: assert property (shutdown |=> shutdown && $stable(last_trip))
      else $error("released");
   chk_shut_cause: assert property (shutdown |-> last_trip != EXC_TRIP_NONE)
      else $error("no cause");
   chk_ot_trip: assert property (meas.temp > 8'h46 |-> ##[1:3] (shutdown && alarm_relay))
      else $error("no ot trip");
   chk_no_option: assert property (!option_fitted [*4] |-> active_mode < EXC_MODE_VAR)
      else $error("no option");
   chk_contact_off: assert property (contacts.reactive_control_contact [*4]
      |-> active_mode < EXC_MODE_VAR) else $error("contact closed");
   chk_field_clamp: assert property (active_mode == EXC_MODE_FIELD
      |-> active_setpoint <= 16'h0BB8) else $error("field range");
   chk_var_clamp: assert property (active_mode == EXC_MODE_VAR
      |-> $signed(active_setpoint) <= 1000 && $signed(active_setpoint) >= -1000)
      else $error("var range");
   chk_pf_clamp: assert property (active_mode == EXC_MODE_PF
      |-> $signed(active_setpoint) <= 400 && $signed(active_setpoint) >= -400)
      else $error("pf range");
endmodule
bind exc_top exc_checker #(.TICK_CYCLES(TICK_CYCLES)) u_exc_checker (.clock(clock),
   .rst_n(rst_n), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
   .meas(meas), .contacts(contacts), .option_fitted(option_fitted),
   .active_mode(active_mode), .active_setpoint(active_setpoint),
   .alarm_relay(alarm_relay), .shutdown(shutdown), .last_trip(last_trip));

// file: verification/exc_front.sv
// front end model: measured plant values and contact pins
`timescale 1ns/1ps
module exc_front import exc_pkg::*; (
   // clock
   input wire logic clock,
   // wanted plant state
   input wire exc_pkg::exc_meas_t meas_set,
   input wire exc_pkg::exc_contact_t cont_set,
   // pins toward the supervisor
   output exc_pkg::exc_meas_t meas,
   output exc_pkg::exc_contact_t contacts
);
   initial begin
      meas = '0;
      contacts = '0;
   end
   // contacts held closed while the bench holds them
   always @(posedge clock) begin
      meas <= meas_set;
      contacts <= cont_set;
   end
endmodule

// file: verification/tb_exc_top.sv
// self-checking bench for the excitation supervisor
`timescale 1ns/1ps
`include "exc_regs.svh"
module tb_exc_top;
   import exc_pkg::*;
   localparam int TK = 2;
   logic clock = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic option_fitted = 1'h0, pready, pslverr, alarm_relay, shutdown, er;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rv;
   logic [1:0] boot_trip = 2'h0;
   logic [15:0] active_setpoint;
   exc_meas_t ms = '{16'h03E8, 16'h0000, 16'h1770, 8'h19, 16'h0000};
   exc_contact_t cs = '0;
   exc_meas_t meas;
   exc_contact_t contacts;
   exc_mode_t active_mode;
   exc_ind_t indicators;
   exc_trip_t last_trip;
   int num_errors = 0, tests_run = 0, n;
   always #25 clock = ~clock;
   exc_front u_exc_front (.clock(clock), .meas_set(ms), .cont_set(cs), .meas(meas),
      .contacts(contacts));
   exc_top #(.TICK_CYCLES(TK)) u_exc_top (.clock(clock), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .meas(meas), .contacts(contacts),
      .option_fitted(option_fitted), .boot_trip(boot_trip), .active_mode(active_mode),
      .active_setpoint(active_setpoint), .indicators(indicators),
      .alarm_relay(alarm_relay), .shutdown(shutdown), .last_trip(last_trip));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: %h vs %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop;
      if (num_errors == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic wt(input int c);
      repeat (c) @(posedge clock);
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'h1;
      do @(posedge clock);
      while (pready !== 1'h1);
      rv = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge clock);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'h1, a, d);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      apb(1'h0, a, 32'h0);
      chk(rv, e);
   endtask
   task automatic cnt(input int cyc, input int b);
      n = 0;
      repeat (cyc) begin
         @(posedge clock);
         n += indicators[b];
      end
   endtask
   task automatic rst(input logic [1:0] bt);
      rst_n <= 1'h0;
      boot_trip <= bt;
      wt(4);
      rst_n <= 1'h1;
      wt(3);
   endtask
   function automatic int clampv(int v, int lo, int hi);
      return v < lo ? lo : (v > hi ? hi : v);
   endfunction
   function automatic logic [31:0] xmode(int i);
      return (i % 4 >= 2 && !(i[2] && i[4] && !i[3])) ? 0 : i % 4;
   endfunction
   initial begin
      int a[6] = '{`EXC_OFF_FSET, `EXC_OFF_DROOP, `EXC_OFF_KNEE, `EXC_OFF_SLOPE,
         `EXC_OFF_QSET, `EXC_OFF_PFSET};
      int lo[6] = '{0, 0, 4000, 100, -1000, -400};
      int hi[6] = '{3000, 100, 6500, 300, 1000, 400};
      int iqs[4] = '{1000, -1000, 0, 500};
      int v, q, k;
      void'($urandom(90582));
      rst(2'h0);
      rdchk(`EXC_OFF_VSET, 32'h3E8);
      rdchk(`EXC_OFF_KNEE, 32'h170C);
      rdchk(`EXC_OFF_SLOPE, 32'hC8);
      rdchk(`EXC_OFF_UNLD, 32'h01020109);
      rdchk(`EXC_OFF_FOVSET, 32'h320);
      rdchk(`EXC_OFF_GOVSET, 32'h4B0);
      rdchk(8'h30, 32'h0);
      chk(er, 1'h1);
      wr(`EXC_OFF_UNLD, 32'hFFFFFFFF);
      rdchk(`EXC_OFF_UNLD, 32'h0514FF5A);
      wr(`EXC_OFF_UNLD, 32'h0);
      rdchk(`EXC_OFF_UNLD, 32'h01010009);
      for (int i = 0; i < 48; i++) begin
         k = i % 6;
         v = i < 6 ? 32'h7FFF : (i < 12 ? 32'h8000 : $urandom_range(32'hFFFF));
         q = clampv(k > 3 ? int'($signed(16'(v))) : v, lo[k], hi[k]);
         wr(a[k], v);
         rdchk(a[k], 32'(q) & 32'hFFFF);
      end
      wr(`EXC_OFF_KNEE, 32'h170C);
      wr(`EXC_OFF_SLOPE, 32'hC8);
      for (int i = 0; i < 32; i++) begin
         option_fitted <= i[2];
         cs.reactive_control_contact <= i[3];
         wr(`EXC_OFF_CTRL, 32'(i[4] * 4 + i % 4));
         wt(6);
         chk(active_mode, xmode(i));
      end
      option_fitted <= 1'h0;
      cs.reactive_control_contact <= 1'h0;
      cs.parallel_comp_contact <= 1'h1;
      wr(`EXC_OFF_CTRL, 32'h0);
      wr(`EXC_OFF_VSET, 32'h3E8);
      cs.raise <= 1'h1;
      wt(100 * TK);
      cs.raise <= 1'h0;
      cs.lower <= 1'h1;
      wt(8);
      chk(active_setpoint inside {[16'h03EF:16'h03F5]}, 1'h1);
      wt(100 * TK - 8);
      cs.lower <= 1'h0;
      wt(8);
      chk(active_setpoint inside {[16'h03E5:16'h03EB]}, 1'h1);
      wr(`EXC_OFF_VSET, 32'h3E8);
      wr(`EXC_OFF_DROOP, 32'h64);
      cs.parallel_comp_contact <= 1'h0;
      foreach (iqs[j]) begin
         ms.iq <= 16'(iqs[j]);
         wt(8);
         chk(active_setpoint, 16'(1000 - iqs[j] / 10));
      end
      cs.parallel_comp_contact <= 1'h1;
      wt(8);
      chk(active_setpoint, 16'h03E8);
      option_fitted <= 1'h1;
      wt(8);
      chk(active_setpoint, 16'h03B6);
      option_fitted <= 1'h0;
      ms.iq <= 16'h0000;
      ms.freq <= 16'h16DA;
      wt(100);
      apb(1'h0, `EXC_OFF_STATUS, 32'h0);
      chk(rv[5:4], 2'h1);
      ms.freq <= 16'h1770;
      wt(100);
      ms.freq <= 16'h1388;
      wt(100);
      apb(1'h0, `EXC_OFF_STATUS, 32'h0);
      chk(rv[5], 1'h1);
      wt(1000 * TK + 200);
      apb(1'h0, `EXC_OFF_STATUS, 32'h0);
      chk(rv[5], 1'h0);
      chk(active_setpoint inside {[16'h02B6:16'h02B7]}, 1'h1);
      cnt(1200, 3);
      chk(n > 0 && n < 1200, 1'h1);
      ms.freq <= 16'h1770;
      ms.vrms <= 16'h0514;
      wt(750 * TK - 100);
      chk(shutdown, 1'h0);
      cnt(1100, 1);
      chk({shutdown, alarm_relay, last_trip}, {2'h3, EXC_TRIP_GOV});
      chk(n > 0, 1'h1);
      ms.vrms <= 16'h03E8;
      wt(8);
      chk({shutdown, alarm_relay}, 2'h2);
      rst(2'h2);
      cnt(1000, 1);
      chk(n > 0, 1'h1);
      wt(5000 * TK);
      cnt(1000, 1);
      chk(n, 0);
      ms.temp <= 8'h46;
      wt(20);
      chk(shutdown, 1'h0);
      ms.temp <= 8'h47;
      wt(20);
      chk({shutdown, last_trip}, {1'h1, EXC_TRIP_OT});
      ms.temp <= 8'h19;
      rst(2'h0);
      wr(`EXC_OFF_CTRL, 32'h8);
      ms.vfield <= 16'h0384;
      cnt(1100, 2);
      chk(n > 0, 1'h1);
      wt(15000 * TK - 1300);
      chk({shutdown, alarm_relay}, 2'h0);
      wt(400);
      chk({shutdown, alarm_relay, last_trip}, {2'h3, EXC_TRIP_FOV});
      report_and_stop();
   end
   // tests take about 49000 cycles
   initial begin
      #4000000;
      num_errors++;
      report_and_stop();
   end
endmodule
